//--- prr_pkg.sv
package prr_pkg;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  PWR_RED_OFFSET   = 8'h64;
   localparam logic [7:0]  MCU_CTRL_OFFSET  = 8'h68;
   localparam logic [7:0]  SYS_CTRL_OFFSET  = 8'h6C;
   localparam logic [7:0]  STATUS_OFFSET    = 8'h70;

   localparam logic [7:0]  PWR_RED_RESET    = 8'h00;
   localparam logic [7:0]  PWR_RED_WMASK    = 8'hEF;

   // power reduction bit positions
   localparam int TWI_BIT    = 7;
   localparam int TIM2_BIT   = 6;
   localparam int TIM0_BIT   = 5;
   localparam int RSVD_BIT   = 4;
   localparam int TIM1_BIT   = 3;
   localparam int SPI_BIT    = 2;
   localparam int USART_BIT  = 1;
   localparam int ADC_BIT    = 0;

   // mcu control bit positions
   localparam int BOD_SLEEP_OFF_BIT   = 6;
   localparam int BOD_SLEEP_WRITE_ENABLE_BIT  = 5;

   // system control bit positions
   localparam int T2ASYNC_BIT = 0;
   localparam int COMPARATOR_BANDGAP_SELECT_BIT    = 1;
   localparam int ADCEN_BIT   = 2;

   // status bit positions
   localparam int ST_BOD_SLEEP_OFF_BIT  = 0;
   localparam int ST_WIN_BIT   = 1;
   localparam int ST_BG_BIT    = 2;
   localparam int ST_BODOFF_BIT = 3;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int          SEQ_WINDOW_CYC   = 4;
   localparam int          BOD_SLEEP_OFF_DELAY_CYC   = 3;
   localparam int          BOD_SLEEP_OFF_ACTIVE_CYC  = 3;
   localparam int          DELAY_W          = 24;

   localparam logic [1:0]  AXI_OKAY   = 2'h0;
   localparam logic [1:0]  AXI_SLVERR = 2'h2;

   typedef struct packed {
      logic twowire_interface;
      logic tim2;
      logic tim0;
      logic tim1;
      logic spi;
      logic usart;
      logic adc;
   } clk_en_t;

   typedef struct packed {
      logic por_n;
      logic ext_n;
      logic wdt;
      logic bod_n;
   } rst_src_t;

endpackage

//--- bod_sleep_seq.sv
`timescale 1ns/1ps
module bod_sleep_seq
   import prr_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic wr,
   input  wire logic bod_sleep_off_w,
   input  wire logic bod_sleep_write_enable_w,
   output logic      bod_sleep_off_q,
   output logic      win_q,
   output logic      active_q
);
   logic [2:0] win_cnt_q;
   logic [2:0] age_q;

   // --------------------------------------------------------------------
   // enable window
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_q <= 3'h0;
      end else if (wr && bod_sleep_off_w && bod_sleep_write_enable_w) begin
         win_cnt_q <= 3'(SEQ_WINDOW_CYC);
      end else if (wr || win_cnt_q != 3'h0) begin
         win_cnt_q <= wr ? 3'h0 : win_cnt_q - 3'h1;
      end
   end
   assign win_q = (win_cnt_q != 3'h0);

   // --------------------------------------------------------------------
   // bit set only through the sequence, then auto clear
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bod_sleep_off_q <= 1'b0;
         age_q  <= 3'h0;
      end else if (wr && bod_sleep_off_w && !bod_sleep_write_enable_w && win_q) begin
         bod_sleep_off_q <= 1'b1;
         age_q  <= 3'h0;
      end else if (bod_sleep_off_q) begin
         age_q  <= age_q + 3'h1;
         if (age_q == 3'(BOD_SLEEP_OFF_ACTIVE_CYC - 1)) begin
            bod_sleep_off_q <= 1'b0;
         end
      end
   end

   // active from the third cycle after set until the bit drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= 1'b0;
      end else begin
         active_q <= bod_sleep_off_q && age_q == 3'(BOD_SLEEP_OFF_DELAY_CYC - 2);
      end
   end
endmodule // bod_sleep_seq

//--- reset_ctrl.sv
`timescale 1ns/1ps
module reset_ctrl
   import prr_pkg::*;
#(
   parameter int DW = DELAY_W
)(
   input  wire logic          clk,
   input  wire rst_src_t      src,
   input  wire logic          ext_dis,
   input  wire logic          bod_en,
   input  wire logic [DW-1:0] delay,
   output logic               io_rst_n,
   output logic               int_rst_n_q
);
   logic          any_n;
   logic [DW-1:0] cnt_q;

   // asynchronous combination of the four sources
   assign any_n = src.por_n && (src.ext_n || ext_dis) && !src.wdt
                  && (src.bod_n || !bod_en);
   assign io_rst_n = any_n;

   // --------------------------------------------------------------------
   // stretch: counter starts when the last source drops
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge any_n) begin
      if (!any_n) begin
         cnt_q       <= '0;
         int_rst_n_q <= 1'b0;
      end else if (cnt_q < delay) begin
         cnt_q       <= cnt_q + 1'b1;
         int_rst_n_q <= 1'b0;
      end else begin
         int_rst_n_q <= 1'b1;
      end
   end
endmodule // reset_ctrl

//--- power_reduction_reset_control.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module power_reduction_reset_control
   import prr_pkg::*;
#(
   parameter int DW = DELAY_W
)(
   input  wire logic                   SYS_CLK,
   input  wire logic                   NRST,
   // axi4-lite slave
   input  wire logic [7:0]             S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [31:0]            S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output logic [1:0]                  S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   input  wire logic [7:0]             S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [31:0]                 S_AXI_RDATA,
   output logic [1:0]                  S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY,
   // reset sources and fuses
   input  wire prr_pkg::rst_src_t      RST_SRC,
   input  wire logic                   EXT_RESET_DISABLE_FUSE,
   input  wire logic                   BROWNOUT_ENABLE_FUSE,
   input  wire logic [DW-1:0]          RESET_DELAY_CYCLES,
   input  wire logic                   SLEEP_EXEC,
   // outputs
   output prr_pkg::clk_en_t            CLK_EN,
   output logic                        ADC_MUX_AVAIL,
   output logic                        BANDGAP_ON,
   output logic                        BROWNOUT_SLEEP_OFF,
   output logic                        IO_RST_N,
   output logic                        INT_RST_N
);
   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [7:0]     pwr_red_q;
   logic [2:0]     sys_ctrl_q;
   logic [7:0]     aw_addr_q;
   logic [31:0]    w_data_q;
   logic [3:0]     w_strb_q;
   logic           aw_have_q;
   logic           w_have_q;
   logic           wr_go;
   logic           wr_lane0;
   logic           bod_sleep_off_q;
   logic           win_q;
   logic           active_q;
   logic           io_rst_n;
   logic           int_rst_n;
   logic           rst_n;
   logic [1:0]     sync_src_q [4];
   rst_src_t       src_s;
   logic [1:0]     sleep_sync_q;
   logic           bod_off_q;
   logic           io_rst_s1_q;
   logic           io_rst_s2_q;
   logic [31:0]    rd_val;
   logic           rd_ok;

   if (DW < 2 || DW > 32) begin : g_bad_dw
      $error("DW out of range");
   end

   // ----------------------------------------------------------------------
   // reset combination and stretch
   // ----------------------------------------------------------------------
   // sources enter the stretch logic raw: their assertion must act with no
   // clock, only their release is timed by the counter
   reset_ctrl #(
      .DW (DW)
   ) u_rst (
      .clk         (SYS_CLK),
      .src         (RST_SRC),
      .ext_dis     (EXT_RESET_DISABLE_FUSE),
      .bod_en      (BROWNOUT_ENABLE_FUSE),
      .delay       (RESET_DELAY_CYCLES),
      .io_rst_n    (io_rst_n),
      .int_rst_n_q (int_rst_n)
   );

   // every register in the block except the source synchronisers, the port-reset flops and the stretch counter falls back to its initial value
   assign rst_n = NRST && int_rst_n;

   // synchronised copies of the sources for the status register
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge SYS_CLK or negedge NRST) begin
            if (!NRST) begin
               sync_src_q[gi] <= 2'h0;
            end else begin
               sync_src_q[gi] <= {sync_src_q[gi][0], RST_SRC[gi]};
            end
         end
      end
   endgenerate
   assign src_s = {sync_src_q[3][1], sync_src_q[2][1],
                   sync_src_q[1][1], sync_src_q[0][1]};

   // port reset leaves through two flops; clear is asynchronous so it needs
   // no clock, release is resynchronised
   always_ff @(posedge SYS_CLK or negedge io_rst_n) begin
      if (!io_rst_n) begin
         io_rst_s1_q <= 1'b0;
         io_rst_s2_q <= 1'b0;
      end else begin
         io_rst_s1_q <= 1'b1;
         io_rst_s2_q <= io_rst_s1_q;
      end
   end
   assign IO_RST_N = io_rst_s2_q;

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         INT_RST_N <= 1'b0;
      end else begin
         INT_RST_N <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite write
   // ----------------------------------------------------------------------
   assign wr_go    = aw_have_q && w_have_q && !S_AXI_BVALID;
   assign wr_lane0 = w_strb_q[0];

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_have_q <= 1'b1;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
      end else begin
         S_AXI_AWREADY <= !aw_have_q && !(S_AXI_AWVALID && S_AXI_AWREADY);
         S_AXI_WREADY  <= !w_have_q && !(S_AXI_WVALID && S_AXI_WREADY);
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= AXI_OKAY;
      end else if (wr_go) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= (aw_addr_q == PWR_RED_OFFSET ||
                          aw_addr_q == MCU_CTRL_OFFSET ||
                          aw_addr_q == SYS_CTRL_OFFSET ||
                          aw_addr_q == STATUS_OFFSET) ? AXI_OKAY : AXI_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pwr_red_q <= PWR_RED_RESET;
      end else if (wr_go && wr_lane0 && aw_addr_q == PWR_RED_OFFSET) begin
         pwr_red_q <= w_data_q[7:0] & PWR_RED_WMASK;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sys_ctrl_q <= 3'h0;
      end else if (wr_go && wr_lane0 && aw_addr_q == SYS_CTRL_OFFSET) begin
         sys_ctrl_q <= w_data_q[2:0];
      end
   end

   bod_sleep_seq u_bod_sleep_off (
      .clk      (SYS_CLK),
      .rst_n    (rst_n),
      .wr       (wr_go && wr_lane0 && aw_addr_q == MCU_CTRL_OFFSET),
      .bod_sleep_off_w   (w_data_q[BOD_SLEEP_OFF_BIT]),
      .bod_sleep_write_enable_w  (w_data_q[BOD_SLEEP_WRITE_ENABLE_BIT]),
      .bod_sleep_off_q   (bod_sleep_off_q),
      .win_q    (win_q),
      .active_q (active_q)
   );

   // ----------------------------------------------------------------------
   // sleep hook: detector stays off for a sleep under way in the active_q cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sleep_sync_q <= 2'h0;
      end else begin
         sleep_sync_q <= {sleep_sync_q[0], SLEEP_EXEC};
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         bod_off_q <= 1'b0;
      end else if (sleep_sync_q[1] && !bod_off_q) begin
         bod_off_q <= active_q;
      end else if (!sleep_sync_q[1]) begin
         bod_off_q <= 1'b0;
      end
   end
   assign BROWNOUT_SLEEP_OFF = bod_off_q;

   // ----------------------------------------------------------------------
   // clock enables: registered so each edge of a gate lands cleanly
   // ----------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         CLK_EN <= '0;
      end else begin
         CLK_EN.twowire_interface   <= !pwr_red_q[TWI_BIT];
         CLK_EN.tim2  <= !(pwr_red_q[TIM2_BIT] &&
                           !sys_ctrl_q[T2ASYNC_BIT]);
         CLK_EN.tim0  <= !pwr_red_q[TIM0_BIT];
         CLK_EN.tim1  <= !pwr_red_q[TIM1_BIT];
         CLK_EN.spi   <= !pwr_red_q[SPI_BIT];
         CLK_EN.usart <= !pwr_red_q[USART_BIT];
         CLK_EN.adc   <= !pwr_red_q[ADC_BIT];
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ADC_MUX_AVAIL <= 1'b0;
         BANDGAP_ON    <= 1'b0;
      end else begin
         ADC_MUX_AVAIL <= !pwr_red_q[ADC_BIT];
         BANDGAP_ON    <= BROWNOUT_ENABLE_FUSE || sys_ctrl_q[COMPARATOR_BANDGAP_SELECT_BIT]
                          || sys_ctrl_q[ADCEN_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite read
   // ----------------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      unique case (S_AXI_ARADDR)
         PWR_RED_OFFSET: rd_val[7:0] = pwr_red_q & PWR_RED_WMASK;
         MCU_CTRL_OFFSET: rd_val[BOD_SLEEP_OFF_BIT] = bod_sleep_off_q;
         SYS_CTRL_OFFSET: rd_val[2:0] = sys_ctrl_q;
         STATUS_OFFSET: begin
            rd_val[ST_BOD_SLEEP_OFF_BIT]   = active_q;
            rd_val[ST_WIN_BIT]    = win_q;
            rd_val[ST_BG_BIT]     = BANDGAP_ON;
            rd_val[ST_BODOFF_BIT] = bod_off_q;
            rd_val[11:8]          = src_s;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= AXI_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RDATA   <= rd_val;
         S_AXI_RRESP   <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (S_AXI_RVALID) begin
         S_AXI_RVALID  <= !S_AXI_RREADY;
         S_AXI_ARREADY <= S_AXI_RREADY;
      end else begin
         S_AXI_ARREADY <= 1'b1;
      end
   end
endmodule // power_reduction_reset_control

//--- prrc_props.sv
`timescale 1ns/1ps
module prrc_props
   import prr_pkg::*;
(
   input wire logic              SYS_CLK,
   input wire logic              NRST,
   input wire prr_pkg::rst_src_t RST_SRC,
   input wire logic              EXT_RESET_DISABLE_FUSE,
   input wire logic              BROWNOUT_ENABLE_FUSE,
   input wire logic              SLEEP_EXEC,
   input wire prr_pkg::clk_en_t  CLK_EN,
   input wire logic              ADC_MUX_AVAIL,
   input wire logic              BANDGAP_ON,
   input wire logic              BROWNOUT_SLEEP_OFF,
   input wire logic              IO_RST_N,
   input wire logic              INT_RST_N
);
   // ---------------------------------------------------------------
   // reset and power checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   a_por_now: assert property (!RST_SRC.por_n |-> !IO_RST_N)
      else $error("io reset missing on supply drop");
   a_ext_pin: assert property (
      (!RST_SRC.ext_n && !EXT_RESET_DISABLE_FUSE) |-> !IO_RST_N)
      else $error("io reset missing on pin reset");
   a_bod_low: assert property (
      (!RST_SRC.bod_n && BROWNOUT_ENABLE_FUSE) |-> !IO_RST_N)
      else $error("io reset missing on brown-out");
   a_wdt_pulse: assert property (RST_SRC.wdt |-> !IO_RST_N)
      else $error("io reset missing on watchdog pulse");
   a_stretch_after: assert property ($rose(INT_RST_N) |-> $past(IO_RST_N, 2))
      else $error("internal reset released before stretch");
   a_bandgap_fuse: assert property (
      (BROWNOUT_ENABLE_FUSE && INT_RST_N) |-> ##[0:2] BANDGAP_ON)
      else $error("bandgap off while detector enabled");
   a_mux_adc: assert property (INT_RST_N |-> ADC_MUX_AVAIL == CLK_EN.adc)
      else $error("comparator mux free while adc shut down");
   a_sleep_cause: assert property (BROWNOUT_SLEEP_OFF |->
      ($past(SLEEP_EXEC) || $past(SLEEP_EXEC, 2) ||
       $past(SLEEP_EXEC, 3) || $past(SLEEP_EXEC, 4)))
      else $error("detector off without sleep");

   c_wdt: cover property (RST_SRC.wdt ##1 !INT_RST_N);
   c_sleep_off: cover property ($rose(BROWNOUT_SLEEP_OFF));
   c_stretch: cover property ($rose(INT_RST_N));
endmodule // prrc_props

//--- rst_src_model.sv
`timescale 1ns/1ps
module rst_src_model
   import prr_pkg::*;
(
   input wire logic       clk,
   input wire logic [3:0] req,
   output prr_pkg::rst_src_t src
);
   // ---------------------------------------------------------------
   // detectors: levels for supply, pin, brown-out; watchdog pulses
   // ---------------------------------------------------------------
   logic wdt_q = 1'b0;
   logic req_q = 1'b0;

   // watchdog fires one clock wide however long the request lasts
   // plain always: the power-up values above must not fight a sole driver
   always @(posedge clk) begin
      req_q <= req[3];
      wdt_q <= req[3] && !req_q;
   end
   assign src = '{por_n: !req[0], ext_n: !req[1],
                  wdt: wdt_q, bod_n: !req[2]};
endmodule // rst_src_model

//--- power_reduction_reset_control_tb_top.sv
`timescale 1ns/1ps
module power_reduction_reset_control_tb_top;
   import prr_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [23:0] RST_DLY = 24'h000004;
   logic        clk = 1'b0, nrst = 1'b0, sleep = 1'b0;
   logic        ext_dis = 1'b0, bod_fuse = 1'b1;
   logic [3:0]  req = 4'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic        mux, bg, bso, io_rst_n, int_rst_n;
   rst_src_t    rst_src;
   clk_en_t     clk_en;
   int          mismatches = 0, check_count = 0;

   always #5 clk = ~clk;

   power_reduction_reset_control DUT (
      .SYS_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(1'b1), .RST_SRC(rst_src),
      .EXT_RESET_DISABLE_FUSE(ext_dis), .BROWNOUT_ENABLE_FUSE(bod_fuse),
      .RESET_DELAY_CYCLES(RST_DLY), .SLEEP_EXEC(sleep), .CLK_EN(clk_en),
      .ADC_MUX_AVAIL(mux), .BANDGAP_ON(bg), .BROWNOUT_SLEEP_OFF(bso),
      .IO_RST_N(io_rst_n), .INT_RST_N(int_rst_n));

   rst_src_model u_src (.clk(clk), .req(req), .src(rst_src));

   // ---------------------------------------------------------------
   // common tasks
   // ---------------------------------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic hang(input string nm);
      mismatches++;
      $display("wrong value %s expected answer seen timeout", nm);
      print_verdict();
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // bready and rready stay high, so the answer is taken when seen
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      resp = bresp;
      if (n == 40) hang("bvalid");
   endtask

   task automatic axi_rd(input logic [7:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      resp = rresp;
      if (n == 40) hang("rvalid");
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_prr;
      logic [7:0] v;
      logic [6:0] e;
      axi_rd(PWR_RED_OFFSET);
      check("prr reset", d, {24'h0, PWR_RED_RESET});
      axi_wr(SYS_CTRL_OFFSET, 32'h0);
      for (int i = 0; i < 8; i++) begin
         v = 8'h01 << i;
         e = ~{v[7], v[6], v[5], v[3], v[2], v[1], v[0]};
         axi_wr(PWR_RED_OFFSET, {24'h0, v});
         axi_rd(PWR_RED_OFFSET);
         check("prr bit", d, {24'h0, v & 8'hEF});
         wait_cyc(3);
         check("clk en", clk_en, e);
         check("adc mux", mux, !v[0]);
      end
      axi_wr(PWR_RED_OFFSET, 32'h40);
      axi_wr(SYS_CTRL_OFFSET, 32'h1);
      wait_cyc(3);
      check("tim2 async", clk_en.tim2, 1'b1);
      axi_wr(PWR_RED_OFFSET, 32'h0);
      axi_wr(SYS_CTRL_OFFSET, 32'h0);
      axi_rd(8'h10);
      check("unmapped resp", resp, AXI_SLVERR);
      $display("test prr done");
   endtask

   task automatic bod_sleep_off_try(input logic arm, input int gap, input logic slp,
                           input logic exp);
      logic seen;
      seen = 1'b0;
      sleep <= slp;
      wait_cyc(4);
      if (arm) axi_wr(MCU_CTRL_OFFSET, 32'h60);
      wait_cyc(gap);
      axi_wr(MCU_CTRL_OFFSET, 32'h40);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (bso === 1'b1) seen = 1'b1;
      end
      check("sleep off", seen, exp);
      sleep <= 1'b0;
      wait_cyc(8);
      axi_rd(MCU_CTRL_OFFSET);
      check("bod_sleep_off clear", d[BOD_SLEEP_OFF_BIT], 1'b0);
      $display("test sleep off done");
   endtask

   task automatic t_bg;
      logic [2:0] m;
      for (int i = 0; i < 8; i++) begin
         m = i[2:0];
         bod_fuse <= m[2];
         axi_wr(SYS_CTRL_OFFSET, {29'h0, m[1:0], 1'b0});
         wait_cyc(4);
         check("bandgap", bg, m[2] | m[1] | m[0]);
         axi_rd(STATUS_OFFSET);
         check("status bg", d[ST_BG_BIT], m[2] | m[1] | m[0]);
      end
      axi_wr(SYS_CTRL_OFFSET, 32'h0);
      $display("test bandgap done");
   endtask

   // a reset must clear the register, a masked source must not
   task automatic rst_try(input int k, input logic exp);
      logic low;
      int cnt;
      low = 1'b0;
      cnt = 0;
      axi_wr(PWR_RED_OFFSET, 32'h21);
      req[k] <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (n == 6) req[k] <= 1'b0;
         if (io_rst_n === 1'b0) low = 1'b1;
         if (int_rst_n === 1'b0) cnt++;
      end
      check("io reset", low, exp);
      check("stretch", cnt > RST_DLY, exp);
      check("released", int_rst_n, 1'b1);
      axi_rd(PWR_RED_OFFSET);
      check("prr after", d, exp ? 32'h0 : 32'h21);
      $display("test reset source %0d done", k);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      for (int n = 0; n < 100 && int_rst_n !== 1'b1; n++) @(posedge clk);
      if (int_rst_n !== 1'b1) hang("int reset release");
      wait_cyc(2);
      t_prr();
      bod_sleep_off_try(1'b1, 0, 1'b1, 1'b1);
      bod_sleep_off_try(1'b0, 0, 1'b1, 1'b0);
      bod_sleep_off_try(1'b1, 8, 1'b1, 1'b0);
      bod_sleep_off_try(1'b1, 0, 1'b0, 1'b0);
      t_bg();
      bod_fuse <= 1'b1;
      for (int k = 0; k < 4; k++) rst_try(k, 1'b1);
      ext_dis <= 1'b1;
      rst_try(1, 1'b0);
      ext_dis <= 1'b0;
      bod_fuse <= 1'b0;
      rst_try(2, 1'b0);
      print_verdict();
   end

   initial begin
      #200000;
      hang("run");
   end
endmodule // power_reduction_reset_control_tb_top

bind power_reduction_reset_control prrc_props u_props (
   .SYS_CLK(SYS_CLK), .NRST(NRST), .RST_SRC(RST_SRC),
   .EXT_RESET_DISABLE_FUSE(EXT_RESET_DISABLE_FUSE),
   .BROWNOUT_ENABLE_FUSE(BROWNOUT_ENABLE_FUSE), .SLEEP_EXEC(SLEEP_EXEC),
   .CLK_EN(CLK_EN), .ADC_MUX_AVAIL(ADC_MUX_AVAIL), .BANDGAP_ON(BANDGAP_ON),
   .BROWNOUT_SLEEP_OFF(BROWNOUT_SLEEP_OFF), .IO_RST_N(IO_RST_N),
   .INT_RST_N(INT_RST_N));
